/* logic/rsw_pkg.sv */
// constants for the reset source and watchdog controller
// assumes one 20 MHz core clock and an 8-bit register port
// Summary of operation
// - pin low resets; hold 12 clocks after
// - pin reset sets cause bit 0
// - write bit4 one forces internal reset
// - clock silent over 100us causes reset
// - clock-loss reset sets cause bit 2
// - comparator low resets when bit5 enabled
// - convert-start low resets when bit6 enabled
// - 21-bit watchdog overflow forces reset
// - after reset watchdog runs, interval 111
// - code a5 enables and restarts watchdog
// - de then ad within 4 disables
// - code ff locks out disable until reset
// - timeout is four to (3+interval) clocks
// - interval written only when bit7 zero
// - control read bit4 shows watchdog active
// - watchdog reset sets cause bit 3
// - write bit1 forces power-on, drives pin
// - power-on sets bit1; others clear it
// - clock-loss detect only with osc bit7
package rsw_pkg;
   localparam logic [7:0] CAUSE_ADDR = 8'hef;
   localparam logic [7:0] WDOG_ADDR = 8'hff;
   localparam logic [7:0] OSC_ADDR = 8'hb2;
   localparam int PIN_BIT = 0;
   localparam int POR_BIT = 1;
   localparam int MCD_BIT = 2;
   localparam int WDT_BIT = 3;
   localparam int SW_BIT = 4;
   localparam int CMP_BIT = 5;
   localparam int CNV_BIT = 6;
   localparam int MCD_EN_BIT = 7;
   localparam int WD_STAT_BIT = 4;
   localparam int WD_IVW_BIT = 7;
   localparam logic [6:0] CAUSE_RST = 7'h02;
   localparam logic [2:0] IVAL_RST = 3'h7;
   localparam logic [7:0] WD_KICK = 8'ha5;
   localparam logic [7:0] WD_DIS1 = 8'hde;
   localparam logic [7:0] WD_DIS2 = 8'had;
   localparam logic [7:0] WD_LOCK = 8'hff;
   localparam logic [2:0] WD_DIS_GAP = 3'h4;
   localparam int WD_WIDTH = 21;
   localparam int CLK_PERIOD_NS = 50;
   localparam int MCD_TIMEOUT_NS = 100000;
   localparam int MCD_CYCLES = (MCD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RST_EXT_CYCLES = 4'hc;
   localparam logic [3:0] SYNC_RST = 4'he;
endpackage : rsw_pkg

/* logic/rsw_wdt_if.sv */
// watchdog carrier between controller and timer
// assumes both ends run on core_clk
`timescale 1ns/1ns
interface rsw_wdt_if;
   logic sys_rst; // system reset level
   logic wr; // write pulse to control
   logic [7:0] wdata; // write data
   logic active; // watchdog running
   logic [2:0] interval; // programmed interval
   logic ovf; // overflow pulse
   modport ctrl (output sys_rst, output wr, output wdata, input active, input interval, input ovf);
   modport wdt (input sys_rst, input wr, input wdata, output active, output interval, output ovf);
endinterface : rsw_wdt_if

/* logic/rsw_mcd.sv */
// clock-loss one-shot, retriggered by a toggling alive input
// assumes alive is already synchronised to core_clk
`timescale 1ns/1ns
module rsw_mcd #(
   parameter int CYCLES = rsw_pkg::MCD_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // control and status
   input wire logic en,
   input wire logic alive,
   output logic timeout
);
   logic alive_d_ff; // previous alive level
   logic [12:0] cnt_ff; // cycles since last edge
   logic timeout_ff;
   assign timeout = timeout_ff;
   // count silence; fire once past the limit
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         alive_d_ff <= 1'b0;
         cnt_ff <= 13'h0;
         timeout_ff <= 1'b0;
      end else begin
         alive_d_ff <= alive;
         timeout_ff <= 1'b0;
         if (!en || alive != alive_d_ff) begin
            cnt_ff <= 13'h0; // retrigger
         end else if (cnt_ff == 13'(CYCLES)) begin
            timeout_ff <= 1'b1; // strictly more than limit
            cnt_ff <= 13'h0;
         end else begin
            cnt_ff <= cnt_ff + 13'h1;
         end
      end
   end
endmodule : rsw_mcd

/* logic/rsw_wdt.sv */
// watchdog timer with kick, two-step disable and lockout
// assumes writes arrive only outside system reset
`timescale 1ns/1ns
module rsw_wdt #(
   parameter int WIDTH = rsw_pkg::WD_WIDTH
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // controller side
   rsw_wdt_if.wdt wd
);
   logic active_ff, lock_ff, ovf_ff;
   logic [2:0] ival_ff, gap_ff;
   logic [WIDTH-1:0] cnt_ff, limit;
   logic is_kick, is_dis;
   // limit is 4^(3+n) = 2^(6+2n)
   assign limit = WIDTH'(1) << (5'd6 + {1'b0, ival_ff, 1'b0});
   assign is_kick = wd.wr && wd.wdata == rsw_pkg::WD_KICK;
   assign is_dis = wd.wr && wd.wdata == rsw_pkg::WD_DIS2 && gap_ff != 3'h0 && !lock_ff;
   assign wd.active = active_ff;
   assign wd.interval = ival_ff;
   assign wd.ovf = ovf_ff;
   // enable, disable and lockout
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         active_ff <= 1'b1;
         lock_ff <= 1'b0;
         ival_ff <= rsw_pkg::IVAL_RST;
      end else if (wd.sys_rst) begin
         active_ff <= 1'b1;
         lock_ff <= 1'b0;
         ival_ff <= rsw_pkg::IVAL_RST;
      end else begin
         if (is_kick) active_ff <= 1'b1;
         else if (is_dis) active_ff <= 1'b0;
         if (wd.wr && wd.wdata == rsw_pkg::WD_LOCK) lock_ff <= 1'b1;
         if (wd.wr && !wd.wdata[rsw_pkg::WD_IVW_BIT]) ival_ff <= wd.wdata[2:0];
      end
   end
   // age of the first disable code, 1..4 accepts the second
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) gap_ff <= 3'h0;
      else if (wd.wr && wd.wdata == rsw_pkg::WD_DIS1) gap_ff <= 3'h1;
      else if (wd.wr || wd.sys_rst || gap_ff == rsw_pkg::WD_DIS_GAP) gap_ff <= 3'h0;
      else if (gap_ff != 3'h0) gap_ff <= gap_ff + 3'h1;
   end
   // counter; lockout write neither starts nor restarts it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= '0;
         ovf_ff <= 1'b0;
      end else begin
         ovf_ff <= 1'b0;
         if (wd.sys_rst || is_kick || !active_ff) cnt_ff <= '0;
         else if (cnt_ff == limit - WIDTH'(1)) begin
            ovf_ff <= 1'b1;
            cnt_ff <= '0;
         end else cnt_ff <= cnt_ff + WIDTH'(1);
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_kick_restart: assert property (is_kick && !wd.sys_rst |=> active_ff && cnt_ff == '0)
      else $error("kick did not restart watchdog");
   a_lock_blocks: assert property (lock_ff && active_ff && !wd.sys_rst |=> active_ff)
      else $error("locked watchdog was disabled");
   a_reset_ival: assert property (wd.sys_rst |=> ival_ff == 3'h7 && active_ff)
      else $error("interval not maximum after reset");
   a_ovf_time: assert property (ovf_ff |-> $past(cnt_ff) == limit - WIDTH'(1))
      else $error("overflow at wrong count");
   c_disable: cover property (active_ff ##1 !active_ff);
endmodule : rsw_wdt

/* logic/rsw_ctrl.sv */
// reset source collector: pin, software, clock loss, comparator,
// convert-start and watchdog combine into one system reset
// assumes rst is the power-on reset and pins are asynchronous
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
module rsw_ctrl (
   // clock and power-on reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // bidirectional reset pin, active low
   input wire logic rst_pin_n_i,
   output logic rst_pin_n_o,
   output logic rst_pin_n_oe,
   // reset source inputs
   input wire logic cmp_out,
   input wire logic conv_start_n,
   input wire logic clk_alive,
   // system reset to the rest of the chip
   output logic sys_rst
);
   // reset sequence states
   typedef enum logic [1:0] {
      ST_RUN,
      ST_HOLD,
      ST_EXTEND
   } rsw_state_t;

   rsw_state_t state_ff, nxt_state;
   logic [3:0] sync1_ff; // first stage, read only by stage two
   logic [3:0] sync2_ff; // {alive, cnv_n, cmp, pin_n}
   logic [6:0] cause_ff, nxt_cause; // one-hot, bit = register bit
   logic [3:0] ext_ff; // extension countdown
   logic sys_rst_ff;
   logic por_drive_ff; // drives the pin low
   logic cmp_en_ff, cnv_en_ff; // write-only enables
   logic mcd_en_ff; // clock-loss detect enable
   logic [7:0] rdata_ff;
   logic wr_ok, cause_wr, wdog_wr, osc_wr;
   logic pin_low, cmp_hi, cnv_low, alive_s;
   logic sw_req, por_req, cmp_req, cnv_req;
   logic mcd_to, hold_req, any_req;

   rsw_wdt_if wd ();

   // pin inputs cross two flops before use
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= rsw_pkg::SYNC_RST;
         sync2_ff <= rsw_pkg::SYNC_RST;
      end else begin
         sync1_ff <= {clk_alive, conv_start_n, cmp_out, rst_pin_n_i};
         sync2_ff <= sync1_ff;
      end
   end

   assign cmp_hi = sync2_ff[1]; // high while plus above minus
   assign cnv_low = !sync2_ff[2];
   assign alive_s = sync2_ff[3];
   // our own drive pulls the pin low, so ignore it then; the echo of that
   // drive through the synchroniser only stretches the hold a little, and a
   // real external low must still be heard after a power-on cause
   assign pin_low = !sync2_ff[0] && !por_drive_ff;

   // register decode; the cpu is held while in reset
   assign wr_ok = reg_wr && state_ff == ST_RUN;
   assign cause_wr = wr_ok && reg_addr == rsw_pkg::CAUSE_ADDR;
   assign wdog_wr = wr_ok && reg_addr == rsw_pkg::WDOG_ADDR;
   assign osc_wr = wr_ok && reg_addr == rsw_pkg::OSC_ADDR;

   // writing zero to the force bits does nothing
   assign sw_req = cause_wr && reg_wdata[rsw_pkg::SW_BIT];
   assign por_req = cause_wr && reg_wdata[rsw_pkg::POR_BIT];
   // level sources, active low
   assign cmp_req = cmp_en_ff && !cmp_hi;
   assign cnv_req = cnv_en_ff && cnv_low;

   // clock-loss one-shot
   rsw_mcd u_mcd (
      .core_clk(core_clk),
      .rst(rst),
      .en(mcd_en_ff),
      .alive(alive_s),
      .timeout(mcd_to)
   );

   // watchdog timer
   rsw_wdt u_wdt (
      .core_clk(core_clk),
      .rst(rst),
      .wd(wd.wdt)
   );

   assign wd.sys_rst = sys_rst_ff;
   assign wd.wr = wdog_wr;
   assign wd.wdata = reg_wdata;

   // any request that starts a reset from run
   assign any_req = pin_low || sw_req || por_req || mcd_to || wd.ovf || cmp_req || cnv_req;

   // a level source that is the latched cause keeps the reset held while asserted, even
   // though its enable was cleared on entry
   always_comb begin
      hold_req = pin_low;
      if (cause_ff[rsw_pkg::CMP_BIT] && !cmp_hi) hold_req = 1'b1;
      if (cause_ff[rsw_pkg::CNV_BIT] && cnv_low) hold_req = 1'b1;
   end

   // pick one cause; pin first since it is the loudest
   always_comb begin
      nxt_cause = 7'h00;
      if (pin_low) nxt_cause[rsw_pkg::PIN_BIT] = 1'b1;
      else if (por_req) nxt_cause[rsw_pkg::POR_BIT] = 1'b1;
      else if (sw_req) nxt_cause[rsw_pkg::SW_BIT] = 1'b1;
      else if (mcd_to) nxt_cause[rsw_pkg::MCD_BIT] = 1'b1;
      else if (wd.ovf) nxt_cause[rsw_pkg::WDT_BIT] = 1'b1;
      else if (cmp_req) nxt_cause[rsw_pkg::CMP_BIT] = 1'b1;
      else nxt_cause[rsw_pkg::CNV_BIT] = 1'b1;
   end

   // reset sequence
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RUN: begin
            if (any_req) nxt_state = ST_HOLD;
         end
         ST_HOLD: begin
            if (!hold_req) nxt_state = ST_EXTEND;
         end
         ST_EXTEND: begin
            // a new low on the pin restarts the hold
            if (hold_req) nxt_state = ST_HOLD;
            else if (ext_ff == 4'h1) nxt_state = ST_RUN;
         end
      endcase
   end

   // state and system reset flop
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_HOLD;
         sys_rst_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         sys_rst_ff <= nxt_state != ST_RUN;
      end
   end

   // extension counter, twelve clocks after the last request
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) ext_ff <= rsw_pkg::RST_EXT_CYCLES;
      else if (nxt_state != ST_EXTEND) ext_ff <= rsw_pkg::RST_EXT_CYCLES;
      else if (state_ff == ST_EXTEND) ext_ff <= ext_ff - 4'h1;
   end

   // cause latched at entry only, so it survives release
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) cause_ff <= rsw_pkg::CAUSE_RST;
      else if (state_ff == ST_RUN && any_req) cause_ff <= nxt_cause;
   end

   // pin drive for a forced power-on reset; released when
   // the extension starts so the pin can settle before run
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) por_drive_ff <= 1'b1;
      else if (state_ff == ST_RUN && any_req && !pin_low && por_req) por_drive_ff <= 1'b1;
      else if (nxt_state == ST_EXTEND) por_drive_ff <= 1'b0;
   end

   assign rst_pin_n_o = 1'b0; // open drain, low only
   assign rst_pin_n_oe = por_drive_ff; // other sources leave the pin alone
   assign sys_rst = sys_rst_ff;

   // source enables, kept apart from the cause flags
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmp_en_ff <= 1'b0;
         cnv_en_ff <= 1'b0;
      end else if (sys_rst_ff) begin
         cmp_en_ff <= 1'b0;
         cnv_en_ff <= 1'b0;
      end else if (cause_wr) begin
         cmp_en_ff <= reg_wdata[rsw_pkg::CMP_BIT];
         cnv_en_ff <= reg_wdata[rsw_pkg::CNV_BIT];
      end
   end

   // clock-loss detect enable, off after every reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) mcd_en_ff <= 1'b0;
      else if (sys_rst_ff) mcd_en_ff <= 1'b0;
      else if (osc_wr) mcd_en_ff <= reg_wdata[rsw_pkg::MCD_EN_BIT];
   end

   // read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) rdata_ff <= 8'h00;
      else if (reg_rd) begin
         unique case (reg_addr)
            rsw_pkg::CAUSE_ADDR: rdata_ff <= {1'b0, cause_ff};
            rsw_pkg::WDOG_ADDR: rdata_ff <= {3'h0, wd.active, 1'b0, wd.interval};
            rsw_pkg::OSC_ADDR: rdata_ff <= {mcd_en_ff, 7'h00};
            default: rdata_ff <= 8'h00;
         endcase
      end else rdata_ff <= 8'h00;
   end

   assign reg_rdata = rdata_ff;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_release_min: assert property ($fell(sys_rst_ff) |-> $past(sys_rst_ff, 12))
      else $error("reset released before twelve clocks");
   a_pin_cause: assert property (state_ff == ST_RUN && pin_low |=> sys_rst_ff && cause_ff == 7'h01)
      else $error("pin reset not recorded");
   a_sw_force: assert property (
      state_ff == ST_RUN && sw_req && !pin_low && !por_req
      |=> sys_rst_ff && cause_ff == 7'h10 && !rst_pin_n_oe)
      else $error("software reset wrong");
   a_por_force: assert property (
      state_ff == ST_RUN && por_req && !pin_low
      |=> rst_pin_n_oe && cause_ff == 7'h02 && sys_rst_ff)
      else $error("power-on force wrong");
   a_mcd_cause: assert property ($rose(sys_rst_ff) && cause_ff[2] |-> $past(mcd_to))
      else $error("clock-loss cause without timeout");
   a_wdt_cause: assert property ($rose(sys_rst_ff) && cause_ff[3] |-> $past(wd.ovf))
      else $error("watchdog cause without overflow");
   a_cmp_cause: assert property ($rose(sys_rst_ff) && cause_ff[5] |-> $past(cmp_en_ff) && !$past(cmp_hi))
      else $error("comparator cause wrong");
   a_cnv_cause: assert property ($rose(sys_rst_ff) && cause_ff[6] |-> $past(cnv_en_ff) && $past(cnv_low))
      else $error("convert-start cause wrong");
   a_en_clear: assert property (sys_rst_ff |=> !cmp_en_ff && !cnv_en_ff && !mcd_en_ff)
      else $error("enables survive reset");
   a_cause_single: assert property ($onehot(cause_ff))
      else $error("cause not single");
   a_wdt_reset: assert property (state_ff == ST_RUN && wd.ovf |=> sys_rst_ff ##1 sys_rst_ff)
      else $error("overflow did not reset");

   c_pin_reset: cover property ($fell(sys_rst_ff) && cause_ff[0]);
   c_wdt_reset: cover property ($rose(sys_rst_ff) && cause_ff[3]);
   c_cmp_reset: cover property ($rose(sys_rst_ff) && cause_ff[5]);
   c_por_force: cover property ($rose(rst_pin_n_oe));
endmodule : rsw_ctrl

/* tb/rsw_pin_model.sv */
// external circuitry on the active-low reset pin
// assumes a pull-up on the pin; the device only ever drives it low
`timescale 1ns/1ns
module rsw_pin_model (
   // request from the bench
   pull_low,
   // device side of the pin
   dev_o,
   dev_oe,
   pin_level
);
   input wire logic pull_low; // external reset request
   input wire logic dev_o; // device drive value
   input wire logic dev_oe; // device drives the pin
   output logic pin_level; // resolved wire level
   // wired pin: either party pulls low, else the pull-up wins
   always_comb begin
      pin_level = 1'b1;
      if (pull_low) begin
         pin_level = 1'b0;
      end
      if (dev_oe && !dev_o) begin
         pin_level = 1'b0;
      end
   end
endmodule : rsw_pin_model

/* tb/reset_source_watchdog_ctrl_tb_top.sv */
// self-checking bench for the reset source and watchdog controller
// assumes rsw_ctrl register map 0xef cause, 0xff watchdog, 0xb2 osc
`timescale 1ns/1ns
module reset_source_watchdog_ctrl_tb_top;
   logic core_clk, rst, reg_wr, reg_rd, cmp_out, conv_start_n, clk_alive, alive_run, pull_low;
   logic [7:0] reg_addr, reg_wdata, rd_val;
   wire logic [7:0] reg_rdata;
   wire logic rst_pin_n_o, rst_pin_n_oe, sys_rst, pin_level;
   int err_count, samples_checked, n;
   // device under test
   rsw_ctrl uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_pin_n_i(pin_level),
      .rst_pin_n_o(rst_pin_n_o), .rst_pin_n_oe(rst_pin_n_oe), .cmp_out(cmp_out),
      .conv_start_n(conv_start_n), .clk_alive(clk_alive), .sys_rst(sys_rst));
   // far side of the reset pin
   rsw_pin_model pin (.pull_low(pull_low), .dev_o(rst_pin_n_o), .dev_oe(rst_pin_n_oe), .pin_level(pin_level));
   // 50 ns clock
   always #25 core_clk = ~core_clk;
   // monitored clock activity, stopped to fake a clock loss
   always @(posedge core_clk) begin
      if (alive_run) begin
         clk_alive <= ~clk_alive;
      end
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // one-cycle write strobe
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : bus_wr
   // two writes back to back, strobe held high
   task automatic wr_seq(input logic [7:0] a, input logic [7:0] d1, input logic [7:0] d2);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d1;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wdata <= d2;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr_seq
   // data stands only in the cycle after the strobe, sampled mid-cycle
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      check(reg_rdata, exp);
   endtask : rd_chk
   // bounded wait for a reset level; a run-out ends the test
   task automatic wait_lvl(input logic lvl, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(negedge core_clk);
         cnt++;
      end while (sys_rst !== lvl && cnt < lim);
      if (sys_rst !== lvl) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, sys_rst, lvl);
         finish_test();
      end
   endtask : wait_lvl
   task automatic t_after_por();
      rd_chk(8'hef, 8'h02);
      rd_chk(8'hff, 8'h17);
      rd_chk(8'hb2, 8'h00);
      rd_chk(8'h10, 8'h00); // unmapped place reads zero
   endtask : t_after_por
   task automatic t_soft();
      bus_wr(8'hef, 8'h10);
      wait_lvl(1'b1, 4, n);
      check({7'h0, rst_pin_n_oe}, 8'h00);
      wait_lvl(1'b0, 30, n);
      check({7'h0, n >= 12 && n <= 16}, 8'h01);
      rd_chk(8'hef, 8'h10);
   endtask : t_soft
   task automatic t_pin();
      @(posedge core_clk);
      pull_low <= 1'b1;
      wait_lvl(1'b1, 6, n);
      repeat (5) @(posedge core_clk);
      check({7'h0, rst_pin_n_oe}, 8'h00);
      pull_low <= 1'b0;
      wait_lvl(1'b0, 30, n);
      check({7'h0, n >= 12}, 8'h01);
      rd_chk(8'hef, 8'h01);
   endtask : t_pin
   task automatic t_wdt_ovf();
      bus_wr(8'hff, 8'h00); // shortest interval, 64 cycles
      rd_chk(8'hff, 8'h10);
      bus_wr(8'hff, 8'ha5);
      wait_lvl(1'b1, 100, n);
      check({7'h0, n >= 62 && n <= 68}, 8'h01);
      check({7'h0, rst_pin_n_oe}, 8'h00);
      wait_lvl(1'b0, 30, n);
      rd_chk(8'hef, 8'h08);
      rd_chk(8'hff, 8'h17);
   endtask : t_wdt_ovf
   task automatic t_wdt_dis();
      bus_wr(8'hff, 8'h00);
      bus_wr(8'hff, 8'ha5);
      wr_seq(8'hff, 8'hde, 8'had);
      rd_chk(8'hff, 8'h00);
      repeat (150) @(negedge core_clk);
      check({7'h0, sys_rst}, 8'h00);
      bus_wr(8'hff, 8'ha5);
      rd_chk(8'hff, 8'h10);
      bus_wr(8'hff, 8'hde);
      repeat (5) @(posedge core_clk);
      bus_wr(8'hff, 8'had); // too late, ignored
      rd_chk(8'hff, 8'h10);
      bus_wr(8'hff, 8'hff); // lockout, then kicks stop
      wr_seq(8'hff, 8'hde, 8'had);
      rd_chk(8'hff, 8'h10);
      wait_lvl(1'b1, 100, n);
      wait_lvl(1'b0, 30, n);
      rd_chk(8'hef, 8'h08);
   endtask : t_wdt_dis
   // level source: comparator when use_cmp, else convert-start
   task automatic t_level(input logic use_cmp, input logic [7:0] en, input logic [7:0] prev);
      bus_wr(8'hef, en); // sources already steady and routed, plain write
      rd_chk(8'hef, prev);
      @(posedge core_clk);
      if (use_cmp) cmp_out <= 1'b0;
      else conv_start_n <= 1'b0;
      wait_lvl(1'b1, 6, n);
      check({7'h0, rst_pin_n_oe}, 8'h00);
      repeat (3) @(posedge core_clk);
      cmp_out <= 1'b1;
      conv_start_n <= 1'b1;
      wait_lvl(1'b0, 30, n);
      rd_chk(8'hef, use_cmp ? 8'h20 : 8'h40);
      @(posedge core_clk);
      if (use_cmp) cmp_out <= 1'b0;
      else conv_start_n <= 1'b0;
      repeat (8) @(negedge core_clk);
      check({7'h0, sys_rst}, 8'h00);
      @(posedge core_clk);
      cmp_out <= 1'b1;
      conv_start_n <= 1'b1;
   endtask : t_level
   task automatic t_mcd();
      bus_wr(8'hb2, 8'h80);
      rd_chk(8'hb2, 8'h80);
      @(posedge core_clk);
      alive_run <= 1'b0;
      wait_lvl(1'b1, 2200, n);
      check({7'h0, n >= 2000}, 8'h01);
      check({7'h0, rst_pin_n_oe}, 8'h00);
      @(posedge core_clk);
      alive_run <= 1'b1;
      wait_lvl(1'b0, 30, n);
      rd_chk(8'hef, 8'h04);
      rd_chk(8'hb2, 8'h00);
   endtask : t_mcd
   task automatic t_por();
      bus_wr(8'hef, 8'h02);
      wait_lvl(1'b1, 4, n);
      check({7'h0, pin_level}, 8'h00);
      wait_lvl(1'b0, 40, n);
      rd_chk(8'hef, 8'h02);
   endtask : t_por
   // main sequence
   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {cmp_out, conv_start_n, clk_alive, alive_run, pull_low} = 5'b11010;
      err_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      wait_lvl(1'b0, 40, n);
      t_after_por();
      t_soft();
      t_pin();
      t_wdt_ovf();
      t_level(1'b1, 8'h60, 8'h08);
      t_level(1'b0, 8'h40, 8'h20);
      t_wdt_dis();
      t_mcd();
      t_por();
      finish_test();
   end
endmodule : reset_source_watchdog_ctrl_tb_top
